// ===== include/ntd_pkg.sv
// Shared constants for the target detection and test register bank.
// Assumes an 8-bit register port with 5-bit addresses, as used by the host port.
package ntd_pkg;
  // Register addresses
  localparam logic [4:0] ADDR_DETECT_LEVEL = 5'h18;
  localparam logic [4:0] ADDR_PROTOCOL     = 5'h19;
  localparam logic [4:0] ADDR_PIN_ROUTE    = 5'h1A;
  localparam logic [4:0] ADDR_TEST_MODE    = 5'h1B;
  // Values after reset
  localparam logic [7:0] RESET_BYTE        = 8'h00;
  // Writable bits (everything else reads zero), and the test bits a stop clears
  localparam logic [7:0] DETECT_WMASK      = 8'hEF;
  localparam logic [7:0] PIN_ROUTE_WMASK   = 8'hFF;
  localparam logic [7:0] TEST_MODE_WMASK   = 8'h2F;
  localparam logic [7:0] TEST_STOP_MASK    = 8'h0E;
  // Detection level fields
  localparam int ID_SIZE_LSB   = 6;
  localparam int SDD_EN_BIT    = 5;
  localparam int EXT_RANGE_BIT = 3;
  // Protocol status fields
  localparam int WAKE_BIT      = 7;
  localparam int COLL_BIT      = 6;
  localparam int ALT_CODE_BIT  = 4;
  localparam int SENS_BIT      = 3;
  localparam int TYPEB_BIT     = 2;
  // Pin routing fields
  localparam int OOK_IN_BIT    = 7;
  localparam int SUBC_OUT_BIT  = 6;
  localparam int DIRECT_BIT    = 5;
  localparam int OSEL_BIT      = 4;
  localparam int GAIN2_BIT     = 3;
  localparam int GAIN1_BIT     = 2;
  localparam int FOLLOW_BIT    = 1;
  localparam int AGC_BIT       = 0;
  // Test mode fields
  localparam int LEVEL_TEST_BIT = 5;
  localparam int FAST_CLK_BIT   = 0;
  // Identifier sizes
  localparam logic [1:0] ID_SIZE_BAD = 2'h3;
  localparam logic [3:0] ID_LEN_4    = 4'h4;
  localparam logic [3:0] ID_LEN_7    = 4'h7;
  localparam logic [3:0] ID_LEN_10   = 4'hA;
  // Interrupt status codes
  localparam logic [7:0] IRQ_FIELD   = 8'h04;
  localparam logic [7:0] IRQ_SDD     = 8'h08;
  localparam logic [7:0] IRQ_RX_DONE = 8'h40;
  // Auto anticollision sequencer states
  typedef enum logic [1:0] {
    SDD_IDLE = 2'b00,
    SDD_SEND = 2'b01,
    SDD_DONE = 2'b10
  } ntd_sdd_e;
endpackage

// ===== src/ntd_field_detect.sv
// Field level comparators for wake-up and collision avoidance.
// Assumes field_level_in comes from a converter on clk_in; the collision
// comparator output is asynchronous and is synchronised here.
`timescale 1ns/100ps
module ntd_field_detect (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] field_level_in,
  input  wire logic [2:0] wake_threshold_in,
  input  wire logic       extended_field_range_in,
  input  wire logic       collision_cmp_in,
  output logic            above_wake_level_out,
  output logic            above_collision_level_out
);
  typedef struct packed {
    logic [1:0] coll_sync;
    logic       above_wake;
  } ntd_fd_s;

  ntd_fd_s    st;
  ntd_fd_s    next_st;
  logic [7:0] wake_ref;

  always_comb
  begin
    next_st = st;
    next_st.coll_sync = {st.coll_sync[0], collision_cmp_in};
    // Extended range doubles the span each threshold step covers
    wake_ref = extended_field_range_in ? {wake_threshold_in, 5'h00}
                                       : {1'b0, wake_threshold_in, 4'h0};
    next_st.above_wake = (wake_threshold_in != 3'h0)
                         && (field_level_in >= wake_ref);
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign above_wake_level_out      = st.above_wake;
  assign above_collision_level_out = st.coll_sync[1];
endmodule // ntd_field_detect

// ===== src/ntd_auto_sdd.sv
// Automatic single device detection sequencer: sends the stored identifier
// one byte per cycle, then reports completion for one cycle.
// Assumes the identifier store answers id_index_out in the same cycle.
`timescale 1ns/100ps
module ntd_auto_sdd #(
  parameter int ID_MAX = 10
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       start_in,
  input  wire logic [3:0] id_length_in,
  output logic            id_byte_req_out,
  output logic [3:0]      id_index_out,
  output logic            done_out
);
  typedef struct packed {
    ntd_pkg::ntd_sdd_e state;
    logic [3:0]        idx;
  } ntd_sdd_s;

  ntd_sdd_s st;
  ntd_sdd_s next_st;

  if (ID_MAX < 1 || ID_MAX > 15)
  begin : g_bad_param
    $error("ID_MAX out of range");
  end

  always_comb
  begin
    next_st = st;
    case (st.state)
      ntd_pkg::SDD_IDLE:
      begin
        next_st.idx = 4'h0;
        if (start_in)
          next_st.state = ntd_pkg::SDD_SEND;
      end
      ntd_pkg::SDD_SEND:
      begin
        next_st.idx = st.idx + 4'h1;
        if (st.idx + 4'h1 >= id_length_in)
          next_st.state = ntd_pkg::SDD_DONE;
      end
      ntd_pkg::SDD_DONE:
        next_st.state = ntd_pkg::SDD_IDLE;
      default:
        next_st.state = ntd_pkg::SDD_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st <= '{state: ntd_pkg::SDD_IDLE, idx: 4'h0};
    else
      st <= next_st;
  end

  assign id_byte_req_out = (st.state == ntd_pkg::SDD_SEND);
  assign id_index_out    = st.idx;
  assign done_out        = (st.state == ntd_pkg::SDD_DONE);
endmodule // ntd_auto_sdd

// ===== src/ntd_regs.sv
// Target detection, protocol status and test registers with pin routing.
// Assumes a byte-wide register port on clk_in decoded from the host port,
// and decoder/analog status inputs on clk_in unless noted as pins.
`timescale 1ns/100ps
module ntd_regs #(
  parameter int ADDR_W = 5
) (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic              chip_en_in,
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  input  wire logic              reg_cont_in,
  output logic [7:0]             reg_rdata_out,
  input  wire logic              test_stop_in,
  input  wire logic              card_emulation_in,
  input  wire logic [7:0]        field_level_in,
  input  wire logic              collision_cmp_in,
  input  wire logic              first_cmd_valid_in,
  input  wire logic [1:0]        first_cmd_rate_in,
  input  wire logic              first_cmd_alt_coding_in,
  input  wire logic              first_cmd_sens_in,
  input  wire logic              first_cmd_typeb_in,
  input  wire logic              rx_done_in,
  input  wire logic              irq_clear_in,
  output logic [7:0]             irq_status_out,
  output logic                   irq_out,
  output logic [3:0]             id_length_out,
  output logic                   id_size_err_out,
  output logic                   id_byte_req_out,
  output logic [3:0]             id_index_out,
  input  wire logic              on_off_keying_pin_in,
  input  wire logic              demod_data_in,
  output logic                   decoder_data_out,
  input  wire logic              modulation_pin_in,
  output logic                   modulation_pin_out,
  output logic                   modulation_pin_oe_out,
  input  wire logic              tx_mod_in,
  input  wire logic              rx_subcarrier_in,
  output logic                   tx_modulation_out,
  output logic                   rx_reset_out,
  input  wire logic [2:0]        rssi_level_in,
  input  wire logic [2:0]        agc_level_in,
  output logic [2:0]             rssi_status_out,
  output logic                   second_output_select_out,
  output logic                   second_stage_gain_cut_out,
  output logic                   first_stage_gain_cut_out,
  output logic                   follower_test_out,
  output logic                   field_level_test_out,
  output logic                   fast_coder_clock_out,
  output logic                   test_mode_out
);
  typedef struct packed {
    logic [1:0] en_sync;
    logic [1:0] ook_sync;
    logic [1:0] modin_sync;
    logic [7:0] detect_level;
    logic [4:0] proto;
    logic [7:0] pin_route;
    logic [7:0] test_mode;
    logic [7:0] irq_status;
    logic [7:0] rdata;
    logic       wake_prev;
    logic       decoder_data;
    logic       mod_out;
    logic       mod_oe;
    logic       tx_mod;
    logic [2:0] rssi;
  } ntd_regs_s;

  ntd_regs_s  st;
  ntd_regs_s  next_st;
  logic [1:0] rst_sync;
  logic       rst_n;
  logic       above_wake;
  logic       above_coll;
  logic       sdd_start;
  logic       sdd_done;
  logic       en_low;
  logic       proto_cont_rd;
  logic       first_capture;

  if (ADDR_W < 5)
  begin : g_bad_param
    $error("ADDR_W too narrow for the register map");
  end

  // Reset is released through two flops so all state leaves reset together
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  ntd_field_detect i_ntd_field_detect (
    .clk_in                    (clk_in),
    .rst_n_in                  (rst_n),
    .field_level_in            (field_level_in),
    .wake_threshold_in         (st.detect_level[2:0]),
    .extended_field_range_in   (st.detect_level[ntd_pkg::EXT_RANGE_BIT]),
    .collision_cmp_in          (collision_cmp_in),
    .above_wake_level_out      (above_wake),
    .above_collision_level_out (above_coll)
  );

  ntd_auto_sdd i_ntd_auto_sdd (
    .clk_in          (clk_in),
    .rst_n_in        (rst_n),
    .start_in        (sdd_start),
    .id_length_in    (id_length_out),
    .id_byte_req_out (id_byte_req_out),
    .id_index_out    (id_index_out),
    .done_out        (sdd_done)
  );

  always_comb
  begin
    case (st.detect_level[7:6])
      2'b00:   id_length_out = ntd_pkg::ID_LEN_4;
      2'b01:   id_length_out = ntd_pkg::ID_LEN_7;
      2'b10:   id_length_out = ntd_pkg::ID_LEN_10;
      default: id_length_out = 4'h0;
    endcase
  end
  assign id_size_err_out = (st.detect_level[7:6] == ntd_pkg::ID_SIZE_BAD);

  // A prohibited size never starts the sequencer
  assign sdd_start = first_cmd_valid_in && first_cmd_sens_in && card_emulation_in
                     && st.detect_level[ntd_pkg::SDD_EN_BIT] && !id_size_err_out;
  assign en_low        = !st.en_sync[1];
  assign proto_cont_rd = reg_rd_in && reg_cont_in
                         && (reg_addr_in == ADDR_W'(ntd_pkg::ADDR_PROTOCOL));
  // A command is recorded while the protocol fields are all zero; the first nonzero one after a clear holds
  assign first_capture = first_cmd_valid_in && (st.proto == 5'h00);

  always_comb
  begin
    next_st = st;
    next_st.en_sync    = {st.en_sync[0], chip_en_in};
    next_st.ook_sync   = {st.ook_sync[0], on_off_keying_pin_in};
    next_st.modin_sync = {st.modin_sync[0], modulation_pin_in};
    next_st.wake_prev  = above_wake;

    // Register writes; the protocol register is read-only
    if (reg_wr_in)
    begin
      if (reg_addr_in == ADDR_W'(ntd_pkg::ADDR_DETECT_LEVEL))
        next_st.detect_level = reg_wdata_in & ntd_pkg::DETECT_WMASK;
      else if (reg_addr_in == ADDR_W'(ntd_pkg::ADDR_PIN_ROUTE))
        next_st.pin_route = reg_wdata_in & ntd_pkg::PIN_ROUTE_WMASK;
      else if (reg_addr_in == ADDR_W'(ntd_pkg::ADDR_TEST_MODE))
        next_st.test_mode = reg_wdata_in & ntd_pkg::TEST_MODE_WMASK;
    end
    // Stop ends test mode; a write in the same cycle wins
    if (test_stop_in && !(reg_wr_in && reg_addr_in == ADDR_W'(ntd_pkg::ADDR_TEST_MODE)))
      next_st.test_mode = st.test_mode & ~ntd_pkg::TEST_STOP_MASK;

    if (reg_rd_in)
    begin
      if (reg_addr_in == ADDR_W'(ntd_pkg::ADDR_DETECT_LEVEL))
        next_st.rdata = st.detect_level;
      else if (reg_addr_in == ADDR_W'(ntd_pkg::ADDR_PROTOCOL))
        next_st.rdata = {above_wake, above_coll, 1'b0, st.proto};
      else if (reg_addr_in == ADDR_W'(ntd_pkg::ADDR_PIN_ROUTE))
        next_st.rdata = st.pin_route;
      else if (reg_addr_in == ADDR_W'(ntd_pkg::ADDR_TEST_MODE))
        next_st.rdata = st.test_mode;
      else
        next_st.rdata = ntd_pkg::RESET_BYTE;
    end

    // Clear after a continuous read, but a capture in the same cycle wins
    if (proto_cont_rd)
      next_st.proto = 5'h00;
    if (first_capture)
    begin
      next_st.proto[ntd_pkg::ALT_CODE_BIT] = first_cmd_alt_coding_in;
      next_st.proto[ntd_pkg::SENS_BIT]     = first_cmd_sens_in;
      next_st.proto[ntd_pkg::TYPEB_BIT]    = first_cmd_typeb_in;
      next_st.proto[1:0]                   = first_cmd_rate_in;
    end

    // Interrupt status: events set, host clears, set beats clear
    if (irq_clear_in)
      next_st.irq_status = 8'h00;
    if (card_emulation_in && above_wake && !st.wake_prev)
      next_st.irq_status = next_st.irq_status | ntd_pkg::IRQ_FIELD;
    if (sdd_done)
      next_st.irq_status = next_st.irq_status | ntd_pkg::IRQ_SDD;
    if (rx_done_in)
      next_st.irq_status = next_st.irq_status | ntd_pkg::IRQ_RX_DONE;

    // Pin routing; direct modulation takes the pin over from subcarrier out
    next_st.decoder_data = st.pin_route[ntd_pkg::OOK_IN_BIT] ? st.ook_sync[1]
                                                             : demod_data_in;
    if (st.pin_route[ntd_pkg::DIRECT_BIT])
    begin
      next_st.mod_oe  = 1'b0;
      next_st.mod_out = 1'b0;
      next_st.tx_mod  = st.modin_sync[1];
    end
    else
    begin
      next_st.mod_oe  = 1'b1;
      next_st.mod_out = st.pin_route[ntd_pkg::SUBC_OUT_BIT] ? rx_subcarrier_in
                                                            : tx_mod_in;
      next_st.tx_mod  = tx_mod_in;
    end
    next_st.rssi = st.pin_route[ntd_pkg::AGC_BIT] ? agc_level_in : rssi_level_in;

    // Enable low clears the protocol, routing, test and interrupt registers, not the detection level
    if (en_low)
    begin
      next_st.proto      = 5'h00;
      next_st.pin_route  = ntd_pkg::RESET_BYTE;
      next_st.test_mode  = ntd_pkg::RESET_BYTE;
      next_st.irq_status = 8'h00;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign reg_rdata_out             = st.rdata;
  assign irq_status_out            = st.irq_status;
  assign irq_out                   = |st.irq_status;
  assign decoder_data_out          = st.decoder_data;
  assign modulation_pin_out        = st.mod_out;
  assign modulation_pin_oe_out     = st.mod_oe;
  assign tx_modulation_out         = st.tx_mod;
  assign rx_reset_out              = st.pin_route[ntd_pkg::DIRECT_BIT];
  assign rssi_status_out           = st.rssi;
  assign second_output_select_out  = st.pin_route[ntd_pkg::OSEL_BIT];
  assign second_stage_gain_cut_out = st.pin_route[ntd_pkg::GAIN2_BIT];
  assign first_stage_gain_cut_out  = st.pin_route[ntd_pkg::GAIN1_BIT];
  assign follower_test_out         = st.pin_route[ntd_pkg::FOLLOW_BIT];
  assign field_level_test_out      = st.test_mode[ntd_pkg::LEVEL_TEST_BIT];
  assign fast_coder_clock_out      = st.test_mode[ntd_pkg::FAST_CLK_BIT];
  assign test_mode_out             = |st.test_mode[3:1];

  property p_level_kept;
    @(posedge clk_in) disable iff (!rst_n)
    (en_low && !reg_wr_in) |=> $stable(st.detect_level);
  endproperty
  a_level_kept: assert property (p_level_kept) else $error("level lost");

  property p_id_len;
    @(posedge clk_in) disable iff (!rst_n)
    (st.detect_level[7:6] == 2'b10) |-> (id_length_out == 4'hA);
  endproperty
  a_id_len: assert property (p_id_len) else $error("bad id length");

  property p_sdd_done;
    @(posedge clk_in) disable iff (!rst_n)
    (sdd_start && !id_byte_req_out && !sdd_done) |-> ##[2:12] sdd_done;
  endproperty
  a_sdd_done: assert property (p_sdd_done) else $error("sdd stuck");

  property p_wake_off;
    @(posedge clk_in) disable iff (!rst_n)
    (st.detect_level[2:0] == 3'h0) |=> !above_wake;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake when off");

  property p_live;
    @(posedge clk_in) disable iff (!rst_n)
    (reg_rd_in && reg_addr_in == ADDR_W'(ntd_pkg::ADDR_PROTOCOL))
      |=> (reg_rdata_out[7:6] == $past({above_wake, above_coll}));
  endproperty
  a_live: assert property (p_live) else $error("live bits wrong");

  property p_cont_clear;
    @(posedge clk_in) disable iff (!rst_n)
    (proto_cont_rd && !first_capture) |=> (st.proto == 5'h00);
  endproperty
  a_cont_clear: assert property (p_cont_clear) else $error("no clear");

  property p_rate;
    @(posedge clk_in) disable iff (!rst_n)
    (first_capture && !en_low) |=> (st.proto[1:0] == $past(first_cmd_rate_in));
  endproperty
  a_rate: assert property (p_rate) else $error("rate not captured");

  property p_sdd_irq;
    @(posedge clk_in) disable iff (!rst_n)
    (sdd_done && !en_low) |=> irq_status_out[3] && irq_out;
  endproperty
  a_sdd_irq: assert property (p_sdd_irq) else $error("no sdd irq");

  property p_direct;
    @(posedge clk_in) disable iff (!rst_n)
    st.pin_route[ntd_pkg::DIRECT_BIT] |=> !modulation_pin_oe_out;
  endproperty
  a_direct: assert property (p_direct) else $error("mod pin driven");

  property p_subc_out;
    @(posedge clk_in) disable iff (!rst_n)
    (st.pin_route[ntd_pkg::SUBC_OUT_BIT] && !st.pin_route[ntd_pkg::DIRECT_BIT])
      |=> (modulation_pin_oe_out && (modulation_pin_out == $past(rx_subcarrier_in)));
  endproperty
  a_subc_out: assert property (p_subc_out) else $error("subcarrier not routed");

  property p_stop;
    @(posedge clk_in) disable iff (!rst_n)
    (test_stop_in && !reg_wr_in) |=> !test_mode_out;
  endproperty
  a_stop: assert property (p_stop) else $error("test mode stuck");

  c_sdd: cover property (@(posedge clk_in) disable iff (!rst_n) sdd_start ##[2:12] sdd_done);
  c_cap: cover property (@(posedge clk_in) disable iff (!rst_n)
    first_capture ##[1:20] proto_cont_rd);
  c_test: cover property (@(posedge clk_in) disable iff (!rst_n) test_mode_out ##1 test_stop_in);
endmodule // ntd_regs

// ===== tb/ntd_host_model.sv
// Host controller model: byte-wide master on the bank's register port.
// Assumes the bank takes a request on the rising edge of clk_in.
`timescale 1ns/100ps
module ntd_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic [4:0]      addr_out,
  output logic [7:0]      wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic            cont_out
);
  initial
  begin
    addr_out = 5'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    cont_out = 1'b0;
  end
  // Idle data shows the inverse of the last byte, never a stale copy
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk_in) #1;
    addr_out = a;
    wdata_out = v;
    wr_out = 1'b1;
    @(posedge clk_in) #1;
    wr_out = 1'b0;
    wdata_out = ~v;
  endtask
  task automatic rd(input logic [4:0] a, input logic c, output logic [7:0] v);
    @(posedge clk_in) #1;
    addr_out = a;
    cont_out = c;
    rd_out = 1'b1;
    @(posedge clk_in) #1;
    rd_out = 1'b0;
    cont_out = 1'b0;
    @(posedge clk_in) #1;
    v = rdata_in;
  endtask
endmodule // ntd_host_model

// ===== tb/tb.sv
// Self-checking bench for the target detection and test register bank.
// Assumes a 10 MHz clock and the host model on the register port.
`timescale 1ns/100ps
module tb;
  logic       clk_in, rstn, en, stop, card, coll, valid, alt, sens, tyb, rxd, iclr;
  logic       on_off_keying_pin, demod, modi, mp_wire, txm, subc, wr, rd, cont, irq, iderr, idreq;
  logic       dec, mpo, mpoe, txo, rxr, flt, fcc, tm, osel, g2, g1, fol;
  logic [7:0] fld, rdata, wdata, irqs;
  logic [4:0] addr;
  logic [3:0] idlen, idx;
  logic [1:0] rate;
  logic [2:0] rssi, agc, rsso;
  int         bad_count = 0;
  int         compares = 0;
  int         cycles = 0;
  // Modulation pin wire: the bank drives it only while its enable is high
  assign mp_wire = mpoe ? mpo : modi;
  ntd_host_model i_host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .cont_out(cont));
  ntd_regs i_ntd_regs (.clk_in(clk_in), .resetn_in(rstn), .chip_en_in(en),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_cont_in(cont), .reg_rdata_out(rdata), .test_stop_in(stop),
    .card_emulation_in(card), .field_level_in(fld), .collision_cmp_in(coll),
    .first_cmd_valid_in(valid), .first_cmd_rate_in(rate), .first_cmd_alt_coding_in(alt),
    .first_cmd_sens_in(sens), .first_cmd_typeb_in(tyb), .rx_done_in(rxd),
    .irq_clear_in(iclr), .irq_status_out(irqs), .irq_out(irq), .id_length_out(idlen),
    .id_size_err_out(iderr), .id_byte_req_out(idreq), .id_index_out(idx),
    .on_off_keying_pin_in(on_off_keying_pin), .demod_data_in(demod), .decoder_data_out(dec),
    .modulation_pin_in(mp_wire), .modulation_pin_out(mpo), .modulation_pin_oe_out(mpoe),
    .tx_mod_in(txm), .rx_subcarrier_in(subc), .tx_modulation_out(txo),
    .rx_reset_out(rxr), .rssi_level_in(rssi), .agc_level_in(agc),
    .rssi_status_out(rsso), .second_output_select_out(osel), .second_stage_gain_cut_out(g2),
    .first_stage_gain_cut_out(g1), .follower_test_out(fol), .field_level_test_out(flt),
    .fast_coder_clock_out(fcc), .test_mode_out(tm));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic rc(input logic [4:0] a, input logic c, input logic [7:0] e, input string n);
    logic [7:0] v;
    i_host.rd(a, c, v);
    chk(n, v, e);
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      summarize();
    end
  end
  task automatic t_regs();
    rc(5'h18, 1'b0, 8'h00, "detect reset");
    rc(5'h19, 1'b0, 8'h00, "protocol reset");
    rc(5'h1A, 1'b0, 8'h00, "route reset");
    rc(5'h05, 1'b0, 8'h00, "unmapped");
    i_host.wr(5'h18, 8'hFF);
    i_host.wr(5'h19, 8'hFF);
    i_host.wr(5'h1A, 8'hFF);
    i_host.wr(5'h1B, 8'hF1);
    rc(5'h18, 1'b0, 8'hEF, "detect mask");
    rc(5'h19, 1'b0, 8'h00, "protocol read only");
    rc(5'h1A, 1'b0, 8'hFF, "route write");
    rc(5'h1B, 1'b0, 8'h21, "test mask");
    chk("route pins", {4'h0, osel, g2, g1, fol}, 8'h0F);
    chk("fast coder clock", {6'h0, flt, fcc}, 8'h03);
  endtask
  task automatic t_idsize();
    logic [7:0] exp [4] = '{8'h04, 8'h07, 8'h0A, 8'h10};
    for (int k = 0; k < 4; k++)
    begin
      i_host.wr(5'h18, {k[1:0], 6'h00});
      cyc(1);
      chk("id length", {3'h0, iderr, idlen}, exp[k]);
    end
  endtask
  task automatic t_enable();
    en = 1'b0;
    cyc(6);
    en = 1'b1;
    cyc(4);
    rc(5'h18, 1'b0, 8'hC0, "detect kept");
    rc(5'h1A, 1'b0, 8'h00, "route cleared");
    rc(5'h1B, 1'b0, 8'h00, "test cleared");
  endtask
  task automatic t_sdd();
    int n = 0;
    int m = 0;
    card = 1'b1;
    i_host.wr(5'h18, 8'h21);
    fld = 8'hFF;
    coll = 1'b1;
    cyc(5);
    chk("field irq", irqs, 8'h04);
    {valid, sens, rate} = 4'hD;
    cyc(1);
    {valid, sens} = 2'h0;
    // The first byte cycle follows the capture edge directly
    repeat (8)
    begin
      n += idreq;
      m += idreq ? idx : 4'h0;
      cyc(1);
    end
    chk("sdd bytes", n[7:0], 8'h04);
    chk("sdd index", m[7:0], 8'h06);
    rxd = 1'b1;
    cyc(1);
    rxd = 1'b0;
    cyc(2);
    chk("irq status", {irqs[7:1], irq}, 8'h4D);
    iclr = 1'b1;
    cyc(1);
    iclr = 1'b0;
    cyc(2);
    chk("irq cleared", irqs, 8'h00);
    rc(5'h19, 1'b0, 8'hC9, "type a proto");
    rc(5'h19, 1'b1, 8'hC9, "cont read");
    rc(5'h19, 1'b0, 8'hC0, "proto cleared");
  endtask
  // A later command with other values must not replace the first one
  task automatic cap(input logic [4:0] v, input logic [7:0] e);
    {alt, sens, tyb, rate} = v;
    valid = 1'b1;
    cyc(1);
    {alt, sens, tyb, rate} = 5'h14;
    cyc(1);
    valid = 1'b0;
    rc(5'h19, 1'b1, e, "first command");
  endtask
  task automatic t_proto();
    cap(5'h05, 8'hC5);
    cap(5'h12, 8'hD2);
    cap(5'h03, 8'hC3);
    fld = 8'h1F;
    i_host.wr(5'h18, 8'h01);
    rc(5'h19, 1'b0, 8'hC0, "wake normal");
    i_host.wr(5'h18, 8'h09);
    rc(5'h19, 1'b0, 8'h40, "wake extended");
    fld = 8'hFF;
    i_host.wr(5'h18, 8'h00);
    rc(5'h19, 1'b0, 8'h40, "wake off");
    coll = 1'b0;
    cyc(3);
    rc(5'h19, 1'b0, 8'h00, "collision live");
  endtask
  task automatic t_test();
    i_host.wr(5'h1B, 8'h02);
    cyc(1);
    chk("test mode", {7'h0, tm}, 8'h01);
    i_host.wr(5'h1B, 8'h0C);
    rc(5'h1B, 1'b0, 8'h0C, "io test bits");
    stop = 1'b1;
    cyc(1);
    stop = 1'b0;
    cyc(1);
    chk("test stopped", {7'h0, tm}, 8'h00);
    rc(5'h1B, 1'b0, 8'h00, "stop clears");
  endtask
  task automatic t_pins();
    on_off_keying_pin = 1'b1;
    i_host.wr(5'h1A, 8'h80);
    cyc(4);
    chk("decoder input", {7'h0, dec}, 8'h01);
    subc = 1'b1;
    i_host.wr(5'h1A, 8'h40);
    cyc(4);
    chk("subcarrier out", {6'h0, mpoe, mpo}, 8'h03);
    modi = 1'b1;
    i_host.wr(5'h1A, 8'h20);
    cyc(4);
    chk("direct mode", {5'h0, rxr, mpoe, txo}, 8'h05);
    {rssi, agc} = 6'h15;
    cyc(3);
    chk("rssi normal", {5'h0, rsso}, 8'h02);
    i_host.wr(5'h1A, 8'h01);
    cyc(3);
    chk("agc on rssi", {5'h0, rsso}, 8'h05);
  endtask
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial
  begin
    {rstn, stop, card, coll, valid, alt, sens, tyb, rxd, iclr} = '0;
    {on_off_keying_pin, demod, modi, txm, subc, fld, rate, rssi, agc} = '0;
    en = 1'b1;
    cyc(8);
    rstn = 1'b1;
    cyc(4);
    t_regs();
    t_idsize();
    t_enable();
    t_sdd();
    t_proto();
    t_test();
    t_pins();
    summarize();
  end
endmodule // tb
